/* rtl/strobe_calc_pkg.sv */
// Constants, paper tables and carrier types for the strobe width controller.
// Assumes one 10 MHz controller clock shared by the whole controller.
`default_nettype none

package strobe_calc_pkg;

  // Clock and time base
  localparam int CLK_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / HZ_PER_MHZ;

  // Printing energy, in units of 1e-7 mJ and 1e-7 mJ per degree C
  localparam int REF_TEMP_C = 25;
  localparam int PAPER_COUNT = 11;
  localparam logic [23:0] STD_ENERGY [PAPER_COUNT] = '{
    24'h2f64d0, 24'h4054c0, 24'h3d37e0, 24'h31e570, 24'h30acf0,
    24'h3836a0, 24'h34cba0, 24'h2ee7d0, 24'h3b8648, 24'h433320,
    24'h374088};
  localparam logic [16:0] TEMP_COEFF_LO [PAPER_COUNT] = '{
    17'h08494, 17'h0c634, 17'h051fe, 17'h0326e, 17'h08ba6,
    17'h0b37e, 17'h08dd6, 17'h07ce2, 17'h089d0, 17'h0b586,
    17'h07b20};
  localparam logic [16:0] TEMP_COEFF_HI [PAPER_COUNT] = '{
    17'h08494, 17'h0c634, 17'h0abf4, 17'h08836, 17'h08ba6,
    17'h0b37e, 17'h08dd6, 17'h07ce2, 17'h0b1c6, 17'h0b586,
    17'h07b20};

  // Resistances in milliohms
  localparam int ELEM_MOHM = 1_500_000;
  localparam int TRACE_HI_MOHM = 40_000;
  localparam int TRACE_LO_MOHM = 55_000;
  localparam int COMMON_MOHM = 320;

  // Adjusted voltage in microvolts: per-mille gain on millivolts, offset
  localparam int V_GAIN_PERMILLE = 968;
  localparam int V_OFFSET_UV = 598_000;

  // Cycle coefficient in parts per 1e9, cycle in microseconds
  localparam int W_KNEE_US = 2640;
  localparam int C_SLOPE_LO = 132_151;
  localparam int C_BASE_LO_PPB = 360_000_000;
  localparam int C_SLOPE_HI = 80_812;
  localparam int C_BASE_HI_PPB = 496_000_000;
  localparam int C_ONE_PPB = 1_000_000_000;

  // Pause after a strobe, and scale that turns the quotient into us
  localparam int PAUSE_US = 100;
  localparam int T_DEN_SCALE = 10_000;

  // Divider widths
  localparam int NUM_W = 96;
  localparam int DEN_W = 72;
  localparam logic [6:0] DIV_LAST = 7'h5f;

  // Reset value and saturation limit of the elapsed time
  localparam logic [16:0] ELAPSED_RST = 17'h1ffff;
  localparam logic [16:0] ELAPSED_MAX = 17'h1ffff;

  // Operating point of one dot line
  typedef struct packed {
    logic signed [7:0] temp_c;
    logic [9:0] dots;
    logic [15:0] vp_mv;
    logic [15:0] supply_mohm;
    logic low_logic;
    logic [3:0] paper;
  } line_params_t;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_PAUSE = 8'h02,
    ST_LOAD_R = 8'h04,
    ST_DIV_R = 8'h08,
    ST_LOAD_T = 8'h10,
    ST_DIV_T = 8'h20,
    ST_FIN = 8'h40,
    ST_FIRE = 8'h80
  } state_t;

endpackage

`default_nettype wire

/* rtl/strobe_width_ctrl.sv */
// Controller that computes the head strobe width for each dot line and
// drives the strobe, holding off each start until the pause has passed.
// Assumes LINE_I and START_I come from logic on CLK_I.
`default_nettype none

// Summary of operation
// - Width is energy times adjusted R over adjusted V squared, times C.
// - Energy is standard energy less the coefficient times (temp - 25 C).
// - Energy and coefficient come per paper, the coefficient split at 25 C.
// - Adjusted R is (element+trace+(common+supply)*dots) squared / element.
// - Trace is 40 ohm for the higher logic supply, 55 ohm at 3.0 or 3.3 V.
// - Adjusted voltage is 0.968 times the head supply less 0.598 V.
// - Below a 2640 us cycle, C is 132.151 times the cycle / 1e6 plus 0.360.
// - From a 2640 us cycle on, C is 80.812 times the cycle / 1e6 plus 0.496.
// - A coefficient above one is used as exactly one.
// - The cycle runs from the previous strobe start to the end of the present pause.
// - A new strobe starts only after the previous width plus 100 us.
module strobe_width_ctrl
  import strobe_calc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic START_I,
  input wire line_params_t LINE_I,
  output logic STROBE_O,
  output logic BUSY_O,
  output logic DONE_O,
  output logic FAULT_O,
  output logic [15:0] WIDTH_US_O
);

  state_t state_q;
  state_t state_d;
  line_params_t line_q;
  logic [15:0] w_q;
  logic [3:0] us_div_q;
  logic [16:0] elapsed_q;
  logic [15:0] last_w_q;
  logic [15:0] remain_q;
  logic [NUM_W-1:0] num_q;
  logic [DEN_W-1:0] den_q;
  logic [DEN_W-1:0] rem_q;
  logic [6:0] cnt_q;
  logic strobe_q;
  logic busy_q;
  logic done_q;
  logic fault_q;
  logic [15:0] width_q;

  // Microsecond tick and pause check
  wire us_tick = (us_div_q == 4'(CYC_PER_US - 1));
  wire pause_ok = elapsed_q > (17'(last_w_q) + 17'(PAUSE_US));
  wire [15:0] w_now = (elapsed_q > 17'h0ffff) ? 16'hffff
                                              : elapsed_q[15:0];

  // Printing energy, clamped at zero
  wire signed [8:0] dt_s = 9'(line_q.temp_c) - 9'(REF_TEMP_C);
  wire [3:0] paper_ix = (line_q.paper < 4'(PAPER_COUNT)) ? line_q.paper
                                                         : 4'h0;
  wire [23:0] std_e = STD_ENERGY[paper_ix];
  wire [16:0] coeff = dt_s[8] ? TEMP_COEFF_LO[paper_ix]
                              : TEMP_COEFF_HI[paper_ix];
  wire signed [33:0] e_raw = $signed({10'h000, std_e})
                           - $signed({17'h00000, coeff})
                           * 34'(dt_s);
  wire [23:0] e_pos = (e_raw <= 34'sd0) ? 24'h000000 : e_raw[23:0];

  // Adjusted resistance numerator
  wire [16:0] path_mohm = 17'(COMMON_MOHM) + {1'b0, line_q.supply_mohm};
  wire [26:0] trace_mohm = line_q.low_logic ? 27'(TRACE_LO_MOHM)
                                            : 27'(TRACE_HI_MOHM);
  wire [26:0] sum_mohm = 27'(ELEM_MOHM) + trace_mohm
                       + 27'(path_mohm) * 27'(line_q.dots);
  wire [NUM_W-1:0] sum_sq = NUM_W'(sum_mohm) * NUM_W'(sum_mohm);

  // Adjusted voltage in microvolts
  wire signed [27:0] v_uv = $signed(28'(V_GAIN_PERMILLE)
                          * {12'h000, line_q.vp_mv})
                          - 28'(V_OFFSET_UV);
  wire v_ok = v_uv > 28'sd0;
  wire [DEN_W-1:0] v_sq = DEN_W'(v_uv[26:0]) * DEN_W'(v_uv[26:0])
                        * DEN_W'(T_DEN_SCALE);

  // Cycle coefficient in parts per 1e9
  wire [39:0] c_lo = 40'(C_SLOPE_LO) * 40'(w_q) + 40'(C_BASE_LO_PPB);
  wire [39:0] c_hi = 40'(C_SLOPE_HI) * 40'(w_q) + 40'(C_BASE_HI_PPB);
  wire [39:0] c_raw = (w_q < 16'(W_KNEE_US)) ? c_lo : c_hi;
  wire [29:0] c_ppb = (c_raw > 40'(C_ONE_PPB)) ? 30'(C_ONE_PPB)
                                               : c_raw[29:0];
  wire [NUM_W-1:0] t_num = NUM_W'(e_pos) * NUM_W'(num_q[31:0])
                         * NUM_W'(c_ppb);

  // Restoring divider step
  wire [DEN_W:0] rem_sh = {rem_q, num_q[NUM_W-1]};
  wire rem_ge = rem_sh >= {1'b0, den_q};
  wire [DEN_W:0] rem_nx = rem_ge ? rem_sh - {1'b0, den_q} : rem_sh;
  wire div_last = cnt_q == DIV_LAST;
  wire [15:0] t_us = (|num_q[NUM_W-1:16]) ? 16'hffff : num_q[15:0];
  // Launch only a real strobe, so a zero width leaves the timers alone
  wire fire_go = (state_q == ST_FIN) && (t_us != 16'h0000);

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (START_I) state_d = ST_PAUSE;
      ST_PAUSE: if (pause_ok) state_d = ST_LOAD_R;
      ST_LOAD_R: state_d = ST_DIV_R;
      ST_DIV_R: if (div_last) state_d = ST_LOAD_T;
      ST_LOAD_T: state_d = v_ok ? ST_DIV_T : ST_IDLE;
      ST_DIV_T: if (div_last) state_d = ST_FIN;
      ST_FIN: state_d = (t_us == 16'h0000) ? ST_IDLE : ST_FIRE;
      ST_FIRE: if (us_tick && remain_q == 16'h0001) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_q <= ST_IDLE;
    end else if (CE_I) begin
      state_q <= state_d;
    end
  end

  // Time base: microsecond divider and start-to-start elapsed time
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      us_div_q <= 4'h0;
      elapsed_q <= ELAPSED_RST;
    end else if (CE_I) begin
      us_div_q <= (us_tick || fire_go) ? 4'h0 : us_div_q + 4'h1;
      if (fire_go) begin
        elapsed_q <= 17'h00000;
      end else if (us_tick && elapsed_q != ELAPSED_MAX) begin
        elapsed_q <= elapsed_q + 17'h00001;
      end
    end
  end

  // Operating point capture, taken once the pause has passed
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      line_q <= '0;
      w_q <= 16'h0000;
    end else if (CE_I && state_q == ST_PAUSE && pause_ok) begin
      line_q <= LINE_I;
      w_q <= w_now;
    end
  end

  // Divider: R from the squared sum, then the width in microseconds
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      num_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      cnt_q <= 7'h00;
    end else if (CE_I) begin
      if (state_q == ST_LOAD_R || state_q == ST_LOAD_T) begin
        num_q <= (state_q == ST_LOAD_R) ? sum_sq : t_num;
        den_q <= (state_q == ST_LOAD_R) ? DEN_W'(ELEM_MOHM) : v_sq;
        rem_q <= '0;
        cnt_q <= 7'h00;
      end else if (state_q == ST_DIV_R || state_q == ST_DIV_T) begin
        num_q <= {num_q[NUM_W-2:0], rem_ge};
        rem_q <= rem_nx[DEN_W-1:0];
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  // Strobe countdown and previous width for the pause
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      remain_q <= 16'h0000;
      last_w_q <= 16'h0000;
    end else if (CE_I) begin
      if (fire_go) begin
        remain_q <= t_us;
        last_w_q <= t_us;
      end else if (state_q == ST_FIRE && us_tick) begin
        remain_q <= remain_q - 16'h0001;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      strobe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      width_q <= 16'h0000;
    end else if (CE_I) begin
      strobe_q <= state_d == ST_FIRE;
      busy_q <= state_d != ST_IDLE;
      done_q <= state_q != ST_IDLE && state_d == ST_IDLE;
      if (state_q == ST_LOAD_T) begin
        fault_q <= !v_ok; // Non-positive adjusted voltage
      end
      if (fire_go) begin
        width_q <= t_us;
      end
    end
  end

  assign STROBE_O = strobe_q;
  assign BUSY_O = busy_q;
  assign DONE_O = done_q;
  assign FAULT_O = fault_q;
  assign WIDTH_US_O = width_q;

endmodule

`default_nettype wire

/* dv/strobe_width_ctrl_monitor.sv */
// Checker on the strobe controller ports.
// Assumes CE_I stays high, so cycle counts are real time.
`default_nettype none
module strobe_width_ctrl_monitor
  import strobe_calc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic START_I,
  input wire line_params_t LINE_I,
  input wire logic STROBE_O,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic FAULT_O,
  input wire logic [15:0] WIDTH_US_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic st_q;
  logic [19:0] hi_q, len_q, gap_q;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Strobe length, last length, and cycles since the last start
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_q <= 1'b0;
      hi_q <= 20'h00000;
      len_q <= 20'h00000;
      gap_q <= 20'hfffff;
    end else begin
      st_q <= STROBE_O;
      hi_q <= STROBE_O ? hi_q + 20'h00001 : 20'h00000;
      if (st_q && !STROBE_O) len_q <= hi_q;
      if (STROBE_O && !st_q) gap_q <= 20'h00001;
      else if (gap_q != 20'hfffff) gap_q <= gap_q + 20'h00001;
    end
  end
  chk_strobe_len: assert property (
    st_q && !STROBE_O |-> hi_q == WIDTH_US_O * 20'h0000a)
    else $error("strobe length differs from width");
  chk_pause_gap: assert property (
    STROBE_O && !st_q |-> gap_q > len_q + 20'h003e8)
    else $error("strobe restarted before the pause ran out");
  chk_done_end: assert property (
    $fell(STROBE_O) |-> DONE_O && !BUSY_O)
    else $error("strobe end without done");
  chk_done_pulse: assert property (
    DONE_O |-> !BUSY_O ##1 !DONE_O)
    else $error("done not a single idle pulse");
  chk_fault_dark: assert property (
    FAULT_O |-> !STROBE_O)
    else $error("strobe while voltage fault");
  chk_strobe_lat: assert property (
    $rose(STROBE_O) |-> $past(BUSY_O, 196) && BUSY_O)
    else $error("strobe without a full computation");
  chk_width_hold: assert property (
    !(STROBE_O && !st_q) |-> $stable(WIDTH_US_O))
    else $error("width changed outside a strobe start");
  chk_start_take: assert property (
    CE_I && START_I && !BUSY_O |=> BUSY_O)
    else $error("start not taken in idle");
endmodule
bind strobe_width_ctrl strobe_width_ctrl_monitor mon (.CLK_I(CLK_I),
  .ARST_N_I(ARST_N_I), .CE_I(CE_I), .START_I(START_I), .LINE_I(LINE_I),
  .STROBE_O(STROBE_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
  .FAULT_O(FAULT_O), .WIDTH_US_O(WIDTH_US_O));
`default_nettype wire

/* dv/head_model.sv */
// Head model: times strobe starts and the cycles between them.
// Assumes the strobe is sampled on the controller clock.
`default_nettype none
module head_model (
  input wire logic clk_i,
  input wire logic strobe_i,
  output var int rises_o,
  output var int gap_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_q = 100000000;
  logic st_q = 1'b0;
  // Start-to-start cycle of the heat elements
  always @(posedge clk_i) begin
    st_q <= strobe_i;
    if (strobe_i && !st_q) begin
      gap_o <= cnt_q;
      cnt_q <= 1;
      rises_o <= rises_o + 1;
    end else cnt_q <= cnt_q + 1;
  end
endmodule
`default_nettype wire

/* dv/test_strobe_width_ctrl.sv */
// Self-checking bench for the strobe controller: line table, then edges.
// Assumes the head model and the checker are compiled before it.
`default_nettype none
module test_strobe_width_ctrl
  import strobe_calc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {line_params_t p; logic [1:0] kind;} row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  line_params_t line = '0;
  logic strobe, busy, done, fault;
  logic [15:0] width;
  int rises, gap, num_errors = 0, n_compared = 0, cyc = 0;
  bit fresh = 1'b1;
  // Operating points and expected kind: 0 strobe, 1 fault, 2 zero width
  row_t rows [6] = '{
    '{'{8'h14, 10'h120, 16'h6720, 16'h0000, 1'b0, 4'h0}, 2'h0},
    '{'{8'h28, 10'h040, 16'h5460, 16'h01f4, 1'b1, 4'h2}, 2'h0},
    '{'{8'hf6, 10'h3ff, 16'h6720, 16'h0000, 1'b0, 4'h8}, 2'h0},
    '{'{8'h19, 10'h001, 16'h01f4, 16'h0000, 1'b0, 4'h0}, 2'h1},
    '{'{8'h7f, 10'h001, 16'h6720, 16'h0000, 1'b0, 4'h0}, 2'h2},
    '{'{8'h19, 10'h001, 16'h5dc0, 16'h0000, 1'b1, 4'hf}, 2'h0}};
  strobe_width_ctrl dut (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1),
    .START_I(start), .LINE_I(line), .STROBE_O(strobe), .BUSY_O(busy),
    .DONE_O(done), .FAULT_O(fault), .WIDTH_US_O(width));
  head_model head (.clk_i(clk), .strobe_i(strobe), .rises_o(rises),
    .gap_o(gap));
  // Clock and run limit
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 110000) begin
      miss("timeout");
      wrap_up();
    end
  end
  task automatic miss(string m);
    num_errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk_bit(logic g, logic w, string m);
    n_compared++;
    if (g !== w) miss(m);
  endtask
  task automatic chk_width(logic [15:0] g, real w);
    n_compared++;
    if ($isunknown(g) || g > w + 2.0 || g + 2.0 < w) miss("width");
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Expected strobe width in us from the operating point and cycle
  function automatic real want_us(line_params_t p, real w);
    int k, t;
    real e, r, v, c;
    k = p.paper > 4'ha ? 0 : p.paper;
    t = p.temp_c;
    e = 1e-7 * STD_ENERGY[k];
    e -= 1e-7 * (t < 25 ? TEMP_COEFF_LO[k] : TEMP_COEFF_HI[k])
         * (t - 25);
    r = 1500.0 + (p.low_logic ? 55.0 : 40.0);
    r += (0.32 + 1e-3 * p.supply_mohm) * p.dots;
    v = 0.968e-3 * p.vp_mv - 0.598;
    c = w < 2640 ? 132.151e-6 * w + 0.36 : 80.812e-6 * w + 0.496;
    return 1e3 * e * r * r / 1500.0 / (v * v) * (c > 1.0 ? 1.0 : c);
  endfunction
  task automatic run_line(row_t r, logic hold);
    int r0, n;
    logic [15:0] w0;
    real wus;
    r0 = rises;
    w0 = width;
    line = r.p;
    start = 1'b1;
    @(posedge clk);
    #1 start = hold;
    for (n = 0; n < 20000 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    start = 1'b0;
    chk_bit(done, 1'b1, "done");
    chk_bit(fault, r.kind == 2'h1, "fault");
    chk_bit(rises == r0 + (r.kind == 2'h0), 1'b1, "strobe count");
    if (r.kind == 2'h2) chk_bit(width === w0, 1'b1, "width kept");
    if (r.kind == 2'h0) begin
      wus = fresh ? 9999.0 : gap / 10.0 - 19.6;
      chk_width(width, want_us(r.p, wus));
      fresh = 1'b0;
    end
  endtask
  initial begin
    int n;
    repeat (8) @(posedge clk);
    chk_bit({strobe, busy, done, fault, width} == 20'h00000, 1'b1, "rst");
    #1 arst_n = 1'b1;
    foreach (rows[i]) run_line(rows[i], 1'b0);
    $display("table done");
    repeat (22000) @(posedge clk);
    #1 run_line(rows[1], 1'b1);
    $display("long cycle done");
    line = rows[0].p;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    for (n = 0; n < 3000 && strobe !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk_bit(strobe, 1'b1, "strobe before reset");
    arst_n = 1'b0;
    #1 chk_bit(strobe | busy, 1'b0, "async reset");
    @(posedge clk);
    #1 arst_n = 1'b1;
    fresh = 1'b1;
    run_line(rows[0], 1'b0);
    $display("mid reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
